/* cmro_exec.sv */
// Purpose: executes OR, load, move, idle, return-from-irq and rotate ops
// Assumes: file memory answers reg_addr combinationally on reg_rdata
// Notes:   literal ops retire in one cycle, file register ops in two
`timescale 1ns/1ps
`default_nettype none
module cmro_exec
	import cmro_pkg::*;
(
	input  wire logic            clock,         // Core clock, 10 MHz
	input  wire logic            rst_b,         // Synchronous reset, active low
	input  wire logic            instr_valid,   // Fetch offers a word
	input  wire logic [IW-1:0]   instr,         // Instruction word
	output var  logic            instr_ready,   // Executor can take a word
	input  wire logic [DW-1:0]   reg_rdata,     // File register read data
	output var  logic [AW-1:0]   reg_addr,      // File register address
	output var  logic [DW-1:0]   reg_wdata,     // File register write data
	output var  logic            reg_we,        // File register write pulse
	input  wire logic [PCW-1:0]  stack_head,    // Return stack head value
	output var  logic            stack_pop,     // Return stack pop pulse
	output var  logic [DW-1:0]   acc,           // Accumulator
	output var  logic            zero_flag,     // Zero status flag
	output var  logic            carry_flag,    // Carry status flag
	output var  logic [PCW-1:0]  pc,            // Program counter
	output var  logic            global_irq_enable, // Interrupt enable
	output var  logic            retire,        // Instruction finished pulse
	output var  logic            illegal        // Undecoded word pulse
);
	// ---------------------------------------------------------------
	// State and registers
	// ---------------------------------------------------------------
	cmro_state_t       state_q;
	cmro_op_t          op_q;
	logic              dir_q;
	logic              ready_q;
	logic [AW-1:0]     addr_q;
	logic [DW-1:0]     wdata_q;
	logic              we_q;
	logic              pop_q;
	logic [DW-1:0]     acc_q;
	logic              z_q;
	logic              c_q;
	logic [PCW-1:0]    pc_q;
	logic              gie_q;
	logic              retire_q;
	logic              bad_q;

	// Decode of the offered word and the rotate result
	cmro_op_t          op_now;
	logic              take;
	logic [DW-1:0]     rot_val;
	logic [DW-1:0]     or_val;

	assign op_now  = cmro_decode(instr);
	assign take    = instr_valid && ready_q && (state_q == ST_IDLE);
	assign rot_val = {reg_rdata[MSB_BIT-1:0], c_q};
	assign or_val  = acc_q | reg_rdata;

	// ---------------------------------------------------------------
	// Sequencing
	// ---------------------------------------------------------------
	// Register ops hold ready low for their read cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			ready_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					ready_q <= 1'b1;
					if (take && (op_now inside {OP_ORF, OP_STA, OP_CPY, OP_RLC})) begin
						state_q <= ST_READ;
						ready_q <= 1'b0;
					end
				end
				ST_READ: begin
					state_q <= ST_IDLE;
					ready_q <= 1'b1;
				end
			endcase
		end
	end

	// Operand capture; address held until the next register op
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			op_q   <= OP_NOP;
			dir_q  <= 1'b0;
			addr_q <= ADR_RST;
		end else if (take) begin
			op_q  <= op_now;
			dir_q <= instr[DIR_BIT];
			if (op_now inside {OP_ORF, OP_STA, OP_CPY, OP_RLC})
				addr_q <= instr[AW-1:0];
		end
	end

	// ---------------------------------------------------------------
	// File register write back
	// ---------------------------------------------------------------
	// Write strobe lands one cycle after the read cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			we_q    <= 1'b0;
			wdata_q <= ACC_RST;
		end else begin
			we_q <= 1'b0;
			if (state_q == ST_READ) begin
				unique case (op_q)
					OP_ORF: begin
						we_q    <= dir_q;
						wdata_q <= or_val;
					end
					OP_STA: begin
						we_q    <= 1'b1;
						wdata_q <= acc_q;
					end
					OP_CPY: begin
						we_q    <= dir_q;
						wdata_q <= reg_rdata;
					end
					OP_RLC: begin
						we_q    <= dir_q;
						wdata_q <= rot_val;
					end
					default: we_q <= 1'b0;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Accumulator and flags
	// ---------------------------------------------------------------
	// Literal ops act at the take edge, register ops after the read
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			acc_q <= ACC_RST;
			z_q   <= 1'b0;
			c_q   <= 1'b0;
		end else if (take) begin
			if (op_now == OP_ORI) begin
				acc_q <= acc_q | instr[DW-1:0];
				z_q   <= (acc_q | instr[DW-1:0]) == ACC_RST;
			end else if (op_now == OP_LDI) begin
				acc_q <= instr[DW-1:0];
			end
		end else if (state_q == ST_READ) begin
			unique case (op_q)
				OP_ORF: begin
					if (!dir_q)
						acc_q <= or_val;
					z_q <= or_val == ACC_RST;
				end
				OP_CPY: begin
					if (!dir_q)
						acc_q <= reg_rdata;
					z_q <= reg_rdata == ACC_RST;
				end
				OP_RLC: begin
					if (!dir_q)
						acc_q <= rot_val;
					c_q <= reg_rdata[MSB_BIT];
				end
				default: acc_q <= acc_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Program counter, stack and interrupt enable
	// ---------------------------------------------------------------
	// Pop and reload happen together so the head is read only once
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pc_q  <= PC_RST;
			gie_q <= 1'b0;
			pop_q <= 1'b0;
		end else begin
			pop_q <= 1'b0;
			if (take) begin
				if (op_now == OP_RFI) begin
					pc_q  <= stack_head;
					gie_q <= 1'b1;
					pop_q <= 1'b1;
				end else begin
					pc_q <= pc_q + PCW'(1);
				end
			end
		end
	end

	// Completion and undecoded-word pulses
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			retire_q <= 1'b0;
			bad_q    <= 1'b0;
		end else begin
			retire_q <= (take && !(op_now inside {OP_ORF, OP_STA, OP_CPY, OP_RLC}))
				|| (state_q == ST_READ);
			bad_q    <= take && (op_now == OP_BAD);
		end
	end

	// Outputs straight from the flip-flops
	assign instr_ready       = ready_q;
	assign reg_addr          = addr_q;
	assign reg_wdata         = wdata_q;
	assign reg_we            = we_q;
	assign stack_pop         = pop_q;
	assign acc               = acc_q;
	assign zero_flag         = z_q;
	assign carry_flag        = c_q;
	assign pc                = pc_q;
	assign global_irq_enable = gie_q;
	assign retire            = retire_q;
	assign illegal           = bad_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_ORI_RESULT: assert property (
		take && op_now == OP_ORI |=> acc_q == ($past(acc_q) | $past(instr[DW-1:0]))
			&& z_q == (acc_q == ACC_RST))
		else $error("OR immediate result or zero wrong");

	AST_LDI_FLAGS: assert property (
		take && op_now == OP_LDI |=> acc_q == $past(instr[DW-1:0]) && $stable(z_q)
			&& $stable(c_q))
		else $error("Load immediate changed flags or missed value");

	AST_LDI_ENC: assert property (
		(cmro_enc_ldi(acc_q) & LDI_DC) == 14'h0000
			&& cmro_decode(cmro_enc_ldi(acc_q)) == OP_LDI)
		else $error("Load immediate encoding has stray bits");

	AST_ORF_ACC: assert property (
		take && op_now == OP_ORF && !instr[DIR_BIT] |=> ##1
			acc_q == ($past(acc_q) | $past(reg_rdata)) && !reg_we)
		else $error("OR with register to accumulator wrong");

	AST_ORF_REG: assert property (
		take && op_now == OP_ORF && instr[DIR_BIT] |=> ##1
			reg_we && $stable(acc_q) && reg_wdata == (acc_q | $past(reg_rdata)))
		else $error("OR with register to file wrong");

	AST_STA: assert property (
		take && op_now == OP_STA |-> ##2 reg_we && reg_wdata == acc_q
			&& reg_addr == $past(instr[AW-1:0], 2) && $stable(z_q))
		else $error("Store accumulator wrong");

	AST_CPY_ZERO: assert property (
		state_q == ST_READ && op_q == OP_CPY |=> z_q == ($past(reg_rdata) == ACC_RST)
			&& reg_we == dir_q)
		else $error("Copy register zero flag or target wrong");

	AST_RLC: assert property (
		state_q == ST_READ && op_q == OP_RLC |=> c_q == $past(reg_rdata[MSB_BIT])
			&& $stable(z_q) && (dir_q ? reg_wdata : acc_q)
			== {$past(reg_rdata[MSB_BIT-1:0]), $past(c_q)})
		else $error("Rotate left through carry wrong");

	AST_RFI: assert property (
		take && op_now == OP_RFI |=> pc_q == $past(stack_head) && gie_q && stack_pop
			&& $stable(z_q) && $stable(c_q))
		else $error("Return from irq wrong");

	AST_NOP: assert property (
		take && op_now == OP_NOP |=> pc_q == $past(pc_q) + PCW'(1) && $stable(acc_q)
			&& $stable(z_q) && !reg_we && !stack_pop && retire && ready_q)
		else $error("Idle op changed state");

	AST_CPY_ACC: assert property (
		state_q == ST_READ && op_q == OP_CPY && !dir_q |=> acc_q == $past(reg_rdata)
			&& !reg_we && $stable(c_q))
		else $error("Copy register to accumulator wrong");

	AST_RLC_REG: assert property (
		state_q == ST_READ && op_q == OP_RLC && dir_q |=> reg_we && $stable(acc_q)
			&& $stable(z_q))
		else $error("Rotate into register touched more than carry");

	AST_WE_SOURCE: assert property (
		reg_we |-> $past(state_q) == ST_READ && $stable(reg_addr))
		else $error("File write without a read cycle before it");

	AST_POP_SOURCE: assert property (
		stack_pop |-> $past(take) && $past(op_now) == OP_RFI)
		else $error("Stack popped by something other than a return");

	AST_BAD_IDLE: assert property (
		take && op_now == OP_BAD |=> illegal && retire && pc_q == $past(pc_q) + PCW'(1)
			&& $stable(acc_q) && $stable(z_q) && !reg_we)
		else $error("Undecoded word not handled as idle op");

	COV_RLC_REG: cover property (take && op_now == OP_RLC && instr[DIR_BIT] ##2 reg_we);
	COV_CPY_SELF: cover property (take && op_now == OP_CPY && instr[DIR_BIT]);
	COV_RFI_BACK: cover property (take && op_now == OP_RFI ##1 take);
	COV_ORI_ZERO: cover property (take && op_now == OP_ORI ##1 z_q);
	COV_BAD_WORD: cover property (take && op_now == OP_BAD);
endmodule
`default_nettype wire

/* cmro_pkg.sv */
// Purpose: constants, types and helpers for the move/OR/rotate executor
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   opcode patterns are matched as value/mask pairs
// Notes on behaviour
// - OR immediate into accumulator, update zero
// - Load immediate into accumulator, flags kept
// - Load-immediate don't-care bits encoded as zero
// - OR accumulator with register, zero updated
// - Target bit one writes result to register
// - Store accumulator to register, flags kept
// - Copy register to accumulator or itself
// - Copy register updates zero for both targets
// - Rotate left through carry, result per target
// - Rotate to register changes only carry flag
`default_nettype none
package cmro_pkg;
	// ---------------------------------------------------------------
	// Widths and field positions
	// ---------------------------------------------------------------
	localparam int IW       = 14;
	localparam int DW       = 8;
	localparam int AW       = 7;
	localparam int PCW      = 13;
	localparam int DIR_BIT  = 7;
	localparam int MSB_BIT  = 7;

	// ---------------------------------------------------------------
	// Opcode value/mask pairs
	// ---------------------------------------------------------------
	localparam logic [IW-1:0] OPC_ORI  = 14'h3800;
	localparam logic [IW-1:0] MSK_ORI  = 14'h3F00;
	localparam logic [IW-1:0] OPC_LDI  = 14'h3000;
	localparam logic [IW-1:0] MSK_LDI  = 14'h3C00;
	localparam logic [IW-1:0] LDI_DC   = 14'h0300;
	localparam logic [IW-1:0] OPC_ORF  = 14'h0400;
	localparam logic [IW-1:0] MSK_ORF  = 14'h3F00;
	localparam logic [IW-1:0] OPC_STA  = 14'h0080;
	localparam logic [IW-1:0] MSK_STA  = 14'h3F80;
	localparam logic [IW-1:0] OPC_CPY  = 14'h0800;
	localparam logic [IW-1:0] MSK_CPY  = 14'h3F00;
	localparam logic [IW-1:0] OPC_NOP  = 14'h0000;
	localparam logic [IW-1:0] MSK_NOP  = 14'h3F9F;
	localparam logic [IW-1:0] OPC_RFI  = 14'h0009;
	localparam logic [IW-1:0] MSK_RFI  = 14'h3FFF;
	localparam logic [IW-1:0] OPC_RLC  = 14'h0D00;
	localparam logic [IW-1:0] MSK_RLC  = 14'h3F00;

	// ---------------------------------------------------------------
	// Reset values and cycle counts
	// ---------------------------------------------------------------
	localparam logic [DW-1:0]  ACC_RST = 8'h00;
	localparam logic [PCW-1:0] PC_RST  = 13'h0000;
	localparam logic [AW-1:0]  ADR_RST = 7'h00;
	localparam int LIT_CYCLES = 1;
	localparam int REG_CYCLES = 2;

	typedef enum logic [3:0] {
		OP_ORI, OP_LDI, OP_ORF, OP_STA, OP_CPY, OP_NOP, OP_RFI, OP_RLC, OP_BAD
	} cmro_op_t;

	typedef enum logic {ST_IDLE, ST_READ} cmro_state_t;

	// Pattern match used by the decoder
	function automatic logic cmro_hit(input logic [IW-1:0] w, input logic [IW-1:0] opc,
		input logic [IW-1:0] msk);
		return (w & msk) == opc;
	endfunction

	// Instruction classification
	function automatic cmro_op_t cmro_decode(input logic [IW-1:0] w);
		if (cmro_hit(w, OPC_ORI, MSK_ORI)) return OP_ORI;
		if (cmro_hit(w, OPC_LDI, MSK_LDI)) return OP_LDI;
		if (cmro_hit(w, OPC_ORF, MSK_ORF)) return OP_ORF;
		if (cmro_hit(w, OPC_STA, MSK_STA)) return OP_STA;
		if (cmro_hit(w, OPC_CPY, MSK_CPY)) return OP_CPY;
		if (cmro_hit(w, OPC_RFI, MSK_RFI)) return OP_RFI;
		if (cmro_hit(w, OPC_NOP, MSK_NOP)) return OP_NOP;
		if (cmro_hit(w, OPC_RLC, MSK_RLC)) return OP_RLC;
		return OP_BAD;
	endfunction

	// Builds a load-immediate word with don't-care bits at zero
	function automatic logic [IW-1:0] cmro_enc_ldi(input logic [DW-1:0] k);
		return (OPC_LDI & ~LDI_DC) | {6'h00, k};
	endfunction
endpackage
`default_nettype wire

/* tb_cpu_logic_move_rotate_ops.sv */
// Purpose: self-checking bench for the move, OR and rotate executor
// Assumes: file memory and return stack are modelled in this bench
// Notes:   each op is compared against a reference model of core state
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_logic_move_rotate_ops import cmro_pkg::*;;
	// ---------------------------------------------------------------
	// Signals and reference state
	// ---------------------------------------------------------------
	// Index 8 is a word that no pattern decodes
	localparam logic [IW-1:0] op_word [9] = '{OPC_ORI, OPC_LDI, OPC_ORF, OPC_STA,
		OPC_CPY, OPC_NOP, OPC_RFI, OPC_RLC, 14'h3F00};
	logic            clock;
	logic            rst_b;
	logic            instr_valid, instr_ready;
	logic [IW-1:0]   instr;
	logic [DW-1:0]   reg_rdata, reg_wdata, acc;
	logic [AW-1:0]   reg_addr;
	logic            reg_we, stack_pop, zero_flag, carry_flag;
	logic            global_irq_enable, retire, illegal;
	logic [PCW-1:0]  stack_head, pc, m_pc;
	logic [DW-1:0]   mem [128];
	logic [DW-1:0]   mm [128];
	logic [DW-1:0]   m_acc;
	logic            m_z, m_c, m_gie;
	logic [31:0]     seed;
	int              miscompares, comparisons;

	cmro_exec DUT (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.stack_head(stack_head), .stack_pop(stack_pop), .acc(acc),
		.zero_flag(zero_flag), .carry_flag(carry_flag), .pc(pc),
		.global_irq_enable(global_irq_enable), .retire(retire), .illegal(illegal));

	// Clock and file memory; reads are combinational as the core expects
	always #50 clock = ~clock;
	assign reg_rdata = mem[reg_addr];
	// Memory loads the preset image during reset so it has one writer
	always @(posedge clock) begin
		if (!rst_b)
			mem <= mm;
		else if (reg_we === 1'b1)
			mem[reg_addr] <= reg_wdata;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp, input string what);
		comparisons++;
		if (got != exp) begin
			miscompares++;
			$display("wrong value at %0t: %s count %0d want %0d", $time, what, got, exp);
		end
	endtask

	// One instruction: predict, offer, watch three cycles, compare
	task automatic run(input int op, input logic [7:0] k);
		logic [DW-1:0] r;
		logic [AW-1:0] f;
		int            n, lat, rk, nret, pops, wes, ills, ewe, rdy;
		f = k[6:0];
		r = mm[f];
		ewe = 0;
		n = 0;
		while (instr_ready !== 1'b1) begin
			if (n == 20) begin
				miscompares++;
				$display("wrong value at %0t: ready stuck low", $time);
				wrap_up();
			end
			@(negedge clock);
			n++;
		end
		seed = xs(seed);
		stack_head = seed[PCW-1:0];
		instr_valid = 1'b1;
		instr = op_word[op] | ((op == 3) ? {7'h00, f} : (op == 5 || op == 6) ? '0 : {6'h00, k});
		lat = (op == 2 || op == 3 || op == 4 || op == 7) ? REG_CYCLES : LIT_CYCLES;
		case (op)
			0: m_acc = m_acc | k;
			1: m_acc = k;
			2: r = m_acc | r;
			3: begin
				mm[f] = m_acc;
				ewe = 1;
			end
			7: begin
				r = {mm[f][6:0], m_c};
				m_c = mm[f][7];
			end
			default: ;
		endcase
		if (op == 0 || op == 2 || op == 4)
			m_z = (op == 0) ? (m_acc == 8'h00) : (r == 8'h00);
		if (op == 2 || op == 4 || op == 7) begin
			if (k[7]) begin
				mm[f] = r;
				ewe = 1;
			end else begin
				m_acc = r;
			end
		end
		m_pc = (op == 6) ? stack_head : m_pc + 1'b1;
		m_gie = m_gie | (op == 6);
		@(negedge clock);
		// Inputs scrambled after the take so late sampling shows up
		instr_valid = 1'b0;
		seed = xs(seed);
		instr = seed[IW-1:0];
		stack_head = seed[31:19];
		{rk, nret, pops, wes, ills, rdy} = '0;
		for (n = 1; n <= 3; n++) begin
			if (retire === 1'b1 && rk == 0)
				rk = n;
			// An unknown pop, write or illegal strobe counts as a pulse so it cannot hide
			nret += int'(retire === 1'b1);
			pops += int'(stack_pop !== 1'b0);
			wes += int'(reg_we !== 1'b0);
			ills += int'(illegal !== 1'b0);
			rdy += int'(instr_ready !== 1'b1);
			if (n < 3)
				@(negedge clock);
		end
		cmp_cnt(rk, lat, "retire latency");
		cmp_cnt(nret, 1, "retire pulses");
		cmp_cnt(rdy, lat - LIT_CYCLES, "ready low cycles");
		cmp_cnt(pops, int'(op == 6), "stack pops");
		cmp_cnt(wes, ewe, "file writes");
		cmp_cnt(ills, int'(op == 8), "illegal pulses");
		cmp_val(16'(acc), 16'(m_acc), "acc");
		cmp_val(16'(zero_flag), 16'(m_z), "zero");
		cmp_val(16'(carry_flag), 16'(m_c), "carry");
		cmp_val(16'(pc), 16'(m_pc), "pc");
		cmp_val(16'(global_irq_enable), 16'(m_gie), "irq enable");
		cmp_val(16'(mem[f]), 16'(mm[f]), "file reg");
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{clock, instr_valid, instr, stack_head} = '0;
		{m_acc, m_z, m_c, m_gie, m_pc, miscompares, comparisons} = '0;
		rst_b = 1'b0;
		seed = 32'h9181E016;
		for (int i = 0; i < 128; i++) begin
			seed = xs(seed);
			mm[i] = seed[7:0];
		end
		repeat (21) @(negedge clock);
		cmp_val(16'(instr_ready), 16'h0000, "reset ready");
		cmp_val(16'(acc), 16'h0000, "reset acc");
		cmp_val(16'(pc), 16'h0000, "reset pc");
		rst_b = 1'b1;
		// Corner cases: zero results, flags kept, extreme addresses
		run(1, 8'h00);
		run(0, 8'h00);
		run(1, 8'h5A);
		run(3, 8'h7F);
		run(1, 8'h00);
		run(3, 8'h00);
		run(4, 8'h80);
		run(0, 8'hFF);
		run(4, 8'h00);
		run(2, 8'hFF);
		run(1, 8'h81);
		run(3, 8'h10);
		run(7, 8'h90);
		run(7, 8'h10);
		run(2, 8'h10);
		run(5, 8'h00);
		run(6, 8'h00);
		run(8, 8'hA5);
		$display("test corner cases done");
		// Random mix of every decoded op with random operands
		for (int i = 0; i < 400; i++) begin
			seed = xs(seed);
			run(int'(seed[2:0]), seed[15:8]);
		end
		$display("test random mix done");
		wrap_up();
	end
endmodule
`default_nettype wire
